// ===== pchr_cfg_regs.sv
//==========================================================================
// Purpose: configuration header words: command/status, revision/class, misc
// Assumes: one configuration read or write per request, answered next cycle
// Notes:   offsets outside this block's three words read as zero
//==========================================================================
// Function
// - memory enable gates all memory decoding
// - parity enable gates reporting, not detection
// - wait cycle enable reads fixed one
// - address parity error raises SERR when enabled
// - master parity reported bit reads zero
// - devsel timing field reads binary 10
// - generated flag sets whenever SERR asserted
// - SERR only for address parity errors
// - detected flag sets regardless of enable
// - revision byte equals mask revision byte
// - class code reads bridge code fixed
// - header/misc word reads all zero
// - i/o enable gates all i/o decoding
`timescale 1ns/1ps
module pchr_cfg_regs (
    input  wire logic        clk,            // configuration clock, 40 MHz
    input  wire logic        reset,          // synchronous, active high
    input  wire logic        cfg_rd,         // configuration read request
    input  wire logic        cfg_wr,         // configuration write request
    input  wire logic [7:0]  cfg_addr,       // byte offset, dword aligned
    input  wire logic [3:0]  cfg_be,         // byte enables of the write
    input  wire logic [31:0] cfg_wdata,      // write data
    input  wire logic [7:0]  mask_rev,       // mask revision byte
    input  wire logic        addr_perr,      // address parity error, pulse
    input  wire logic        data_perr,      // data parity error, pulse
    input  wire logic        mem_hit,        // memory access hits a window
    input  wire logic        io_hit,         // i/o access hits our range
    output logic [31:0]      cfg_rdata,      // read data, valid with ack
    output logic             cfg_ack,        // request answered, pulse
    output logic             mem_space_en,   // memory decode enable
    output logic             io_space_en,    // i/o decode enable
    output logic             mem_claim,      // memory access claimed
    output logic             io_claim,       // i/o access claimed
    output logic             serr_oe_n,      // system error pin drive
    output logic             perr_oe_n       // parity error pin drive
);
    import pchr_pkg::*;

    //======================================================================
    // command bits and answer registers
    //======================================================================
    logic        io_en_reg;     // i/o space enable
    logic        mem_en_reg;    // memory space enable
    logic        perr_en_reg;   // parity check/report enable
    logic        serr_en_reg;   // system error enable
    logic [31:0] rdata_reg;     // read answer
    logic        ack_reg;       // answer strobe
    logic        mclaim_reg;    // memory claim
    logic        iclaim_reg;    // i/o claim
    logic        det_flag;      // detected flag from error unit
    logic        sig_flag;      // generated flag from error unit

    //======================================================================
    // decode
    //======================================================================
    // a full-byte compare: any offset outside the three words falls to zero
    wire logic sel_cs   = (cfg_addr == OFS_CMD_STAT);
    wire logic sel_rc   = (cfg_addr == OFS_REV_CLASS);
    wire logic sel_hm   = (cfg_addr == OFS_HDR_MISC);
    wire logic wr_cs    = cfg_wr & sel_cs;
    wire logic wr_lane0 = wr_cs & cfg_be[0];
    wire logic wr_lane1 = wr_cs & cfg_be[1];
    // reserved status bits are written zero by software and never stored
    wire logic wr_lane3 = wr_cs & cfg_be[3];
    wire logic clr_det  = wr_lane3 & cfg_wdata[BIT_PERR_DET];
    wire logic clr_sig  = wr_lane3 & cfg_wdata[BIT_SERR_SIG];

    // status/command word as read; reserved bits return zero
    wire logic [31:0] cs_word = {det_flag, sig_flag, 3'b000,
                                 DEVSEL_SLOW,
                                 1'b0,
                                 15'h0000,
                                 serr_en_reg,
                                 1'b1,
                                 perr_en_reg, 4'h0,
                                 mem_en_reg, io_en_reg};
    wire logic [31:0] rc_word = {CLASS_CODE, mask_rev};
    // unmapped offsets answer zero and still get an ack, so a probe never hangs
    wire logic [31:0] rd_next = sel_cs ? cs_word :
                                sel_rc ? rc_word :
                                sel_hm ? HDR_MISC_VAL :
                                ZERO_WORD;

    //======================================================================
    // command register writes
    //======================================================================
    // lanes 0 and 1 hold the writable command bits; lane 2 is all reserved
    always_ff @(posedge clk) begin
        if (reset) begin
            io_en_reg   <= CMD_RESET;
            mem_en_reg  <= CMD_RESET;
            perr_en_reg <= CMD_RESET;
            serr_en_reg <= CMD_RESET;
        end else begin
            if (wr_lane0) begin
                io_en_reg   <= cfg_wdata[BIT_IO_EN];
                mem_en_reg  <= cfg_wdata[BIT_MEM_EN];
                perr_en_reg <= cfg_wdata[BIT_PERR_EN];
            end
            if (wr_lane1) begin
                serr_en_reg <= cfg_wdata[BIT_SERR_EN];
            end
        end
    end

    //======================================================================
    // answers and decode claims
    //======================================================================
    // claims are registered so the window decode sees a clean level; the
    // cost is one cycle of latency on every card access
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg  <= ZERO_WORD;
            ack_reg    <= 1'b0;
            mclaim_reg <= 1'b0;
            iclaim_reg <= 1'b0;
        end else begin
            rdata_reg  <= cfg_rd ? rd_next : ZERO_WORD;
            ack_reg    <= cfg_rd | cfg_wr;
            mclaim_reg <= mem_hit & mem_en_reg;
            iclaim_reg <= io_hit & io_en_reg;
        end
    end

    //======================================================================
    // error flags and pins
    //======================================================================
    pchr_err_unit u_err (
        .clk           (clk),
        .reset         (reset),
        .addr_perr     (addr_perr),
        .data_perr     (data_perr),
        .perr_en       (perr_en_reg),
        .serr_en       (serr_en_reg),
        .clr_det       (clr_det),
        .clr_sig       (clr_sig),
        .det_reg       (det_flag),
        .sig_reg       (sig_flag),
        .serr_oe_n_reg (serr_oe_n),
        .perr_oe_n_reg (perr_oe_n)
    );

    // outputs straight from the flops above, no logic after them
    assign cfg_rdata    = rdata_reg;
    assign cfg_ack      = ack_reg;
    assign mem_space_en = mem_en_reg;
    assign io_space_en  = io_en_reg;
    assign mem_claim    = mclaim_reg;
    assign io_claim     = iclaim_reg;

    //======================================================================
    // checks
    //======================================================================
    a_mem_gate: assert property (@(posedge clk) disable iff (reset)
        mem_claim |-> $past(mem_hit) && $past(mem_space_en))
        else $error("memory claimed while disabled");
    a_io_gate: assert property (@(posedge clk) disable iff (reset)
        $past(io_hit) && !$past(io_space_en) |-> !io_claim)
        else $error("i/o claimed while disabled");
    a_perr_gate: assert property (@(posedge clk) disable iff (reset)
        !perr_oe_n |-> $past(data_perr) && $past(perr_en_reg))
        else $error("parity reported while disabled");
    a_serr_cause: assert property (@(posedge clk) disable iff (reset)
        !serr_oe_n |-> $past(addr_perr) && $past(serr_en_reg) && $past(perr_en_reg))
        else $error("system error without address parity cause");
    a_serr_fire: assert property (@(posedge clk) disable iff (reset)
        addr_perr && serr_en_reg && perr_en_reg |=> !serr_oe_n)
        else $error("system error not raised");
    a_sig_flag: assert property (@(posedge clk) disable iff (reset)
        !serr_oe_n |-> sig_flag)
        else $error("generated flag not set");
    a_det_any: assert property (@(posedge clk) disable iff (reset)
        addr_perr || data_perr |=> det_flag)
        else $error("detected flag not set");
    a_w1c_clear: assert property (@(posedge clk) disable iff (reset)
        clr_det && !addr_perr && !data_perr |=> !det_flag)
        else $error("detected flag not cleared");
    a_fixed_bits: assert property (@(posedge clk) disable iff (reset)
        $past(cfg_rd) && $past(sel_cs) |-> cfg_rdata[BIT_WAIT_EN] &&
        !cfg_rdata[BIT_MDPE] && cfg_rdata[BIT_DEVSEL_LO+1 -: 2] == DEVSEL_SLOW)
        else $error("fixed status bits wrong");
    a_rev_class: assert property (@(posedge clk) disable iff (reset)
        $past(cfg_rd) && $past(sel_rc) |-> cfg_rdata == {CLASS_CODE, $past(mask_rev)})
        else $error("revision/class word wrong");
    a_hdr_zero: assert property (@(posedge clk) disable iff (reset)
        $past(cfg_rd) && $past(sel_hm) |-> cfg_rdata == 32'h0000_0000)
        else $error("header word not zero");

    // write paths and flag lifetimes: these catch a lost lane or a clear beating a set
    a_mem_write: assert property (@(posedge clk) disable iff (reset)
        wr_lane0 |=> mem_space_en == $past(cfg_wdata[BIT_MEM_EN]))
        else $error("memory enable not written");
    a_io_write: assert property (@(posedge clk) disable iff (reset)
        wr_lane0 |=> io_space_en == $past(cfg_wdata[BIT_IO_EN]))
        else $error("i/o enable not written");
    a_det_hold: assert property (@(posedge clk) disable iff (reset)
        det_flag && !clr_det |=> det_flag)
        else $error("detected flag lost");
    a_set_wins: assert property (@(posedge clk) disable iff (reset)
        clr_det && (addr_perr || data_perr) |=> det_flag)
        else $error("clear beat a new parity error");
    a_sig_cause: assert property (@(posedge clk) disable iff (reset)
        $rose(sig_flag) |-> !serr_oe_n)
        else $error("generated flag set without system error");
    a_perr_fire: assert property (@(posedge clk) disable iff (reset)
        data_perr && perr_en_reg |=> !perr_oe_n)
        else $error("parity error not reported");
    a_rev_byte: assert property (@(posedge clk) disable iff (reset)
        $past(cfg_rd) && $past(sel_rc) |-> cfg_rdata[7:0] == $past(mask_rev))
        else $error("revision byte wrong");

    // covers for the main scenarios
    c_serr_seen: cover property (@(posedge clk) disable iff (reset) !serr_oe_n);
    c_clear_race: cover property (@(posedge clk) disable iff (reset) clr_det && data_perr);
    c_mem_claim: cover property (@(posedge clk) disable iff (reset) mem_claim);
    c_io_claim: cover property (@(posedge clk) disable iff (reset) io_claim);
    c_sig_clear: cover property (@(posedge clk) disable iff (reset) sig_flag && clr_sig);
endmodule : pchr_cfg_regs

// ===== pchr_pkg.sv
//==========================================================================
// Purpose: shared constants for the configuration header register block
// Assumes: 32-bit configuration data, dword-aligned byte offsets
// Notes:   all offsets are byte addresses of configuration space
//==========================================================================
package pchr_pkg;
    //======================================================================
    // register offsets
    //======================================================================
    localparam logic [7:0]  OFS_CMD_STAT   = 8'h04;  // command and status
    localparam logic [7:0]  OFS_REV_CLASS  = 8'h08;  // revision and class
    localparam logic [7:0]  OFS_HDR_MISC   = 8'h0c;  // line, latency, header, self test
    //======================================================================
    // field positions
    //======================================================================
    localparam int          BIT_IO_EN      = 0;      // i/o space enable
    localparam int          BIT_MEM_EN     = 1;      // memory space enable
    localparam int          BIT_PERR_EN    = 6;      // parity check/report enable
    localparam int          BIT_WAIT_EN    = 7;      // wait cycle enable, fixed
    localparam int          BIT_SERR_EN    = 8;      // system error enable
    localparam int          BIT_MDPE       = 24;     // master parity reported, fixed
    localparam int          BIT_DEVSEL_LO  = 25;     // devsel timing field low bit
    localparam int          BIT_SERR_SIG   = 30;     // system error generated
    localparam int          BIT_PERR_DET   = 31;     // parity error detected
    //======================================================================
    // fixed and reset values
    //======================================================================
    localparam logic [1:0]  DEVSEL_SLOW    = 2'b10;       // slow decode target
    localparam logic [23:0] CLASS_CODE     = 24'h06_0500; // card bridge class
    localparam logic [31:0] HDR_MISC_VAL   = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
    localparam logic        CMD_RESET      = 1'b0;        // writable bits reset low
endpackage : pchr_pkg

// ===== pchr_err_unit.sv
//==========================================================================
// Purpose: parity error status flags and system error pin drive
// Assumes: parity error inputs are one-cycle pulses from the target logic
// Notes:   pin drives are open drain, enable active low
//==========================================================================
`timescale 1ns/1ps
module pchr_err_unit (
    input  wire logic clk,          // configuration clock
    input  wire logic reset,        // synchronous, active high
    input  wire logic addr_perr,    // address parity error seen, pulse
    input  wire logic data_perr,    // data parity error seen, pulse
    input  wire logic perr_en,      // parity check/report enable
    input  wire logic serr_en,      // system error enable
    input  wire logic clr_det,      // write-one clear of detected flag
    input  wire logic clr_sig,      // write-one clear of generated flag
    output logic      det_reg,      // parity error detected flag
    output logic      sig_reg,      // system error generated flag
    output logic      serr_oe_n_reg,// system error pin drive, low drives
    output logic      perr_oe_n_reg // parity error pin drive, low drives
);
    import pchr_pkg::*;

    //======================================================================
    // decode
    //======================================================================
    // only address parity may raise the system error, and only when both on
    wire logic serr_fire = addr_perr & serr_en & perr_en;
    // data parity reporting is part of the gated reporting circuitry
    wire logic perr_fire = data_perr & perr_en;
    // detect flag ignores the enable on purpose
    wire logic det_set   = addr_perr | data_perr;
    // set wins over clear so an error in the clearing cycle is kept
    wire logic det_next  = det_set | (det_reg & ~clr_det);
    wire logic sig_next  = serr_fire | (sig_reg & ~clr_sig);

    //======================================================================
    // flags and pin drives
    //======================================================================
    always_ff @(posedge clk) begin
        if (reset) begin
            det_reg       <= CMD_RESET;
            sig_reg       <= CMD_RESET;
            serr_oe_n_reg <= 1'b1;
            perr_oe_n_reg <= 1'b1;
        end else begin
            det_reg       <= det_next;
            sig_reg       <= sig_next;
            serr_oe_n_reg <= ~serr_fire;   // one-cycle drive per error
            perr_oe_n_reg <= ~perr_fire;
        end
    end
endmodule : pchr_err_unit

// ===== pchr_host_model.sv
//==========================================================================
// Purpose: host bridge model issuing configuration reads and writes
// Assumes: calls start 2 ns after a rising clock edge
// Notes:   released address and data lines show the inverse of the last value
//==========================================================================
`timescale 1ns/1ps
module pchr_host_model (
    input  wire logic        clk,       // configuration clock
    output logic             cfg_rd,    // read request
    output logic             cfg_wr,    // write request
    output logic [7:0]       cfg_addr,  // byte offset
    output logic [3:0]       cfg_be,    // byte enables
    output logic [31:0]      cfg_wdata  // write data
);
    //======================================================================
    // bus tasks
    //======================================================================
    // quiet bus at time zero
    initial begin
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be    = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    // one request per call; strobes stay up so calls may run back to back
    task automatic req(input logic rd, input logic wr, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d);
        cfg_rd    = rd;
        cfg_wr    = wr;
        cfg_addr  = a;
        cfg_be    = be;
        cfg_wdata = d & 32'hc7ff_ffff; // status bits 29:27 go out as zero
        @(posedge clk);
        #2;
    endtask : req
    // release: inverted lines so a stale value can never pass for a live one
    task automatic idle();
        cfg_rd    = 1'b0;
        cfg_wr    = 1'b0;
        cfg_addr  = ~cfg_addr;
        cfg_wdata = ~cfg_wdata;
        @(posedge clk);
        #2;
    endtask : idle
endmodule : pchr_host_model

// ===== test_pci_config_header_regs.sv
//==========================================================================
// Purpose: self-checking bench for the configuration header registers
// Assumes: inputs change 2 ns after the rising edge
// Notes:   every ack pops the oldest expected read word from a queue
//==========================================================================
`timescale 1ns/1ps
module test_pci_config_header_regs;
    import pchr_pkg::*;
    //======================================================================
    // signals and bench state
    //======================================================================
    logic        clk = 1'b0;                      // 40 MHz clock
    logic        reset = 1'b1;                    // held 16 cycles
    logic        cfg_rd, cfg_wr, cfg_ack;         // request strobes and answer
    logic [7:0]  cfg_addr, mask_rev;              // offset, revision byte
    logic [3:0]  cfg_be;                          // write lanes
    logic [31:0] cfg_wdata, cfg_rdata, d;         // data words
    logic        addr_perr, data_perr, mem_hit, io_hit;
    logic        mem_space_en, io_space_en, mem_claim, io_claim, serr_oe_n, perr_oe_n;
    logic        det, sig, serr_e, perr_e, mem_e, io_e; // expected flags and enables
    logic [31:0] exp_q[$];                        // expected read answers
    int          n_errors = 0;
    int          num_checks = 0;
    int          i;
    always #12.5 clk = ~clk;
    pchr_cfg_regs pchr_cfg_regs_inst (.clk(clk), .reset(reset), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .mask_rev(mask_rev), .addr_perr(addr_perr), .data_perr(data_perr),
        .mem_hit(mem_hit), .io_hit(io_hit), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .mem_space_en(mem_space_en), .io_space_en(io_space_en), .mem_claim(mem_claim),
        .io_claim(io_claim), .serr_oe_n(serr_oe_n), .perr_oe_n(perr_oe_n));
    pchr_host_model pchr_host_model_inst (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    //======================================================================
    // helpers
    //======================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // command/status word as the bench believes it should read
    function automatic logic [31:0] cs();
        cs = {det, sig, 3'h0, DEVSEL_SLOW, 1'b0, 15'h0000, serr_e, 1'b1, perr_e, 4'h0,
              mem_e, io_e};
    endfunction : cs
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        pchr_host_model_inst.req(1'b1, 1'b0, a, 4'h0, $urandom);
    endtask : rd
    // a write answers with an ack and an all-zero data word
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
        exp_q.push_back(32'h0000_0000);
        pchr_host_model_inst.req(1'b0, 1'b1, a, be, v);
    endtask : wr
    // one-cycle error pulse, then pin drives checked in the cycle after it and checked released in the next
    task automatic err(input logic a, input logic p);
        addr_perr = a;
        data_perr = p;
        @(posedge clk);
        #2;
        addr_perr = 1'b0;
        data_perr = 1'b0;
        check("serr_oe_n", serr_oe_n, !(a & serr_e & perr_e));
        check("perr_oe_n", perr_oe_n, !(p & perr_e));
        det = det | a | p;
        sig = sig | (a & serr_e & perr_e);
        @(posedge clk);
        #2;
        check("serr_oe_n", serr_oe_n, 1'b1);
        check("perr_oe_n", perr_oe_n, 1'b1);
    endtask : err
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    //======================================================================
    // answer monitor: oldest note against each acked word
    //======================================================================
    always @(posedge clk) begin
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spare ack", 32'h0000_0001, 32'h0000_0000);
            end else begin
                check("cfg_rdata", cfg_rdata, exp_q.pop_front());
            end
        end
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(4000 * 25);
        n_errors++;
        tally_and_finish();
    end
    //======================================================================
    // main sequence
    //======================================================================
    initial begin
        d = $urandom(32'h0000_862d);
        mask_rev = 8'($urandom);
        {addr_perr, data_perr, mem_hit, io_hit} = 4'h0;
        {det, sig, serr_e, perr_e, mem_e, io_e} = 6'h00;
        repeat (16) @(posedge clk);
        #2;
        reset = 1'b0;
        check("enables", {mem_space_en, io_space_en, serr_oe_n, perr_oe_n}, 4'h3);
        // identity words, unmapped offset and ignored writes, back to back
        rd(OFS_CMD_STAT, cs());
        rd(OFS_REV_CLASS, {CLASS_CODE, mask_rev});
        rd(OFS_HDR_MISC, HDR_MISC_VAL);
        rd(8'h10, ZERO_WORD);
        wr(OFS_REV_CLASS, 4'hf, $urandom);
        wr(OFS_HDR_MISC, 4'hf, $urandom);
        rd(OFS_REV_CLASS, {CLASS_CODE, mask_rev});
        rd(OFS_HDR_MISC, HDR_MISC_VAL);
        pchr_host_model_inst.idle();
        // every enable combination, with decode, errors and flag clearing
        for (i = 0; i < 16; i++) begin
            d = $urandom;
            {serr_e, perr_e, mem_e, io_e} = 4'(i);
            {d[BIT_SERR_EN], d[BIT_PERR_EN], d[BIT_MEM_EN], d[BIT_IO_EN]} = 4'(i);
            wr(OFS_CMD_STAT, 4'h3, d);
            pchr_host_model_inst.idle();
            check("mem_space_en", mem_space_en, mem_e);
            check("io_space_en", io_space_en, io_e);
            repeat (3) begin
                mem_hit = 1'($urandom);
                io_hit = 1'($urandom);
                @(posedge clk);
                #2;
                check("mem_claim", mem_claim, mem_hit & mem_e);
                check("io_claim", io_claim, io_hit & io_e);
            end
            err(1'b1, 1'b0);
            err(1'b0, 1'b1);
            rd(OFS_CMD_STAT, cs());
            // odd passes write zeros, which must leave the flags alone
            wr(OFS_CMD_STAT, 4'h8, (i % 2) ? 32'h0000_0000 : 32'hc000_0000);
            if (i % 2 == 0) begin
                {det, sig} = 2'h0;
            end
            rd(OFS_CMD_STAT, cs());
            pchr_host_model_inst.idle();
        end
        // clear write and a data parity error in one cycle: the set must win
        data_perr = 1'b1;
        wr(OFS_CMD_STAT, 4'h8, 32'hc000_0000);
        data_perr = 1'b0;
        {det, sig} = 2'b10;
        rd(OFS_CMD_STAT, cs());
        pchr_host_model_inst.idle();
        repeat (2) @(posedge clk);
        check("pending answers", 32'(exp_q.size()), 32'h0000_0000);
        tally_and_finish();
    end
endmodule : test_pci_config_header_regs
